//--- pdg_consts.vh
// constants for the deep-sleep port gating and soft reset block
`ifndef PDG_CONSTS_VH
`define PDG_CONSTS_VH

// register bus geometry
`define PDG_ADDR_W          12
`define PDG_DATA_W          32

// register offsets (byte addresses from the system control base)
`define PDG_SRW0_OFS        12'h040
`define PDG_DSG_OFS         12'h128
`define PDG_IRQ_STAT_OFS    12'h1f0
`define PDG_IRQ_MASK_OFS    12'h1f4
`define PDG_EFF_GATE_OFS    12'h1f8

// reset values
`define PDG_SRW0_RST        32'h0000_0000
`define PDG_DSG_RST         32'h0000_0000
`define PDG_ZERO_WORD       32'h0000_0000

// implemented (writable) bits; everything else reads as zero
`define PDG_SRW0_IMPL       32'h0011_0008
`define PDG_DSG_IMPL        32'h0000_001f

// soft reset word field positions
`define PDG_SRW0_PWM_BIT    20
`define PDG_SRW0_ADC0_BIT   16
`define PDG_SRW0_WDOG_BIT   3

// port gating field: bits 4:0 are ports e..a
`define PDG_PORT_MSB        4
`define PDG_NUM_PORTS       5

// power modes
`define PDG_MODE_RUN        2'h0
`define PDG_MODE_SLEEP      2'h1
`define PDG_MODE_DEEP       2'h2

// interrupt event bits
`define PDG_NUM_EVENTS      3
`define PDG_EV_BUS_FAULT    0
`define PDG_EV_RST_MASKED   1
`define PDG_EV_GATE_CHANGE  2

`endif

//--- pdg_event_flags.v
// sticky event flags with write-one-to-clear, mask and level interrupt
`timescale 1ns/10ps
`default_nettype none

module pdg_event_flags #(
  parameter WIDTH = 3
) (
  // clock and reset
  input  wire             clock_in,
  input  wire             rst_in,
  // hardware events, one-cycle pulses
  input  wire [WIDTH-1:0] set_in,
  // software clear, ones clear the matching flag
  input  wire             clear_en_in,
  input  wire [WIDTH-1:0] clear_in,
  // mask, one lets the flag reach the interrupt
  input  wire [WIDTH-1:0] mask_in,
  // state
  output reg  [WIDTH-1:0] flags_out,
  output reg              irq_out
);

  wire [WIDTH-1:0] flags_d;

  // a set in the clearing cycle survives
  assign flags_d = (flags_out & ~({WIDTH{clear_en_in}} & clear_in)) | set_in;

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      flags_out <= {WIDTH{1'b0}};
      irq_out   <= 1'b0;
    end else begin
      flags_out <= flags_d;
      irq_out   <= |(flags_d & mask_in);
    end
  end

endmodule // pdg_event_flags

`default_nettype wire

//--- pdg_gate_reset.v
// deep-sleep port clock gating and first soft reset word
// register map, byte offsets from the control base
//   0x040  soft reset word, bits 20, 16 and 3 writable
//   0x128  deep-sleep port gating word, bits 4:0 writable
//   0x1f0  event status, a one written clears its bit
//   0x1f4  event mask, same layout as the status
//   0x1f8  port enables in force, read only
//
// event status bits
//   0  access to an unclocked or unknown port
//   1  reset asked for a unit that capabilities lack
//   2  port enables changed
//
// limitations
//   run and sleep words, mode and capabilities are plain inputs
//   power mode 3 falls back to the run word
//   port selects 5 to 7 name no unit and always fault
//   reset outputs follow the stored word one clock late
//   read data stand for one clock, then return to zero
//   writes to the read-only enable word are ignored
//   enables change one clock after the mode or word does
`timescale 1ns/10ps
`default_nettype none
`include "pdg_consts.vh"

module pdg_gate_reset #(
  parameter NUM_PORTS = `PDG_NUM_PORTS,
  parameter ADDR_W    = `PDG_ADDR_W,
  parameter DATA_W    = `PDG_DATA_W
) (
  // clock and reset
  input  wire                 clock_in,
  input  wire                 rst_in,
  // register port
  input  wire [ADDR_W-1:0]    reg_addr_in,
  input  wire [DATA_W-1:0]    reg_wdata_in,
  input  wire                 reg_write_in,
  input  wire                 reg_read_in,
  output reg  [DATA_W-1:0]    reg_rdata_out,
  // system control state, same clock
  input  wire [1:0]           power_mode_in,
  input  wire                 auto_clock_gating_enable_in,
  input  wire [NUM_PORTS-1:0] run_port_clock_gate_in,
  input  wire [NUM_PORTS-1:0] sleep_port_clock_gate_in,
  input  wire [DATA_W-1:0]    device_capabilities_1_in,
  // accesses towards the port units
  input  wire                 port_access_in,
  input  wire [2:0]           port_access_sel_in,
  output reg                  bus_fault_out,
  output reg                  port_access_ok_out,
  // port clock enables, bit 0 is port a
  output reg  [NUM_PORTS-1:0] port_clock_enable_out,
  // peripheral resets, active high
  output reg                  pwm_reset_out,
  output reg                  adc0_reset_out,
  output reg                  watchdog_reset_ctl_out,
  // interrupt
  output wire                 irq_out
);

  // decoded register accesses
  wire sel_srw0;
  wire sel_dsg;
  wire sel_stat;
  wire sel_mask;
  wire sel_eff;
  wire mapped;

  assign sel_srw0 = (reg_addr_in == `PDG_SRW0_OFS);
  assign sel_dsg  = (reg_addr_in == `PDG_DSG_OFS);
  assign sel_stat = (reg_addr_in == `PDG_IRQ_STAT_OFS);
  assign sel_mask = (reg_addr_in == `PDG_IRQ_MASK_OFS);
  assign sel_eff  = (reg_addr_in == `PDG_EFF_GATE_OFS);
  assign mapped   = sel_srw0 | sel_dsg | sel_stat | sel_mask | sel_eff;

  // qualified strobes, one write strobe per writable register and one read strobe
  wire wr_srw0;
  wire wr_dsg;
  wire wr_stat;
  wire wr_mask;
  wire rd_take;

  assign wr_srw0 = reg_write_in & sel_srw0;
  assign wr_dsg  = reg_write_in & sel_dsg;
  assign wr_stat = reg_write_in & sel_stat;
  assign wr_mask = reg_write_in & sel_mask;
  // the effective-enable word is read only, so it has no write strobe
  // unmapped reads answer with the zero word of an idle cycle
  assign rd_take = reg_read_in & mapped;

  // stored registers
  reg  [DATA_W-1:0]    srw0_q;
  reg  [DATA_W-1:0]    srw0_d;
  reg  [NUM_PORTS-1:0] dsg_q;
  reg  [NUM_PORTS-1:0] dsg_d;
  reg  [`PDG_NUM_EVENTS-1:0] irq_mask_q;

  // soft reset word write: only implemented units the device really has
  // a refused bit is reported as an event rather than stored
  wire [DATA_W-1:0] srw0_wr_val;
  wire [DATA_W-1:0] srw0_refused;
  assign srw0_wr_val  = reg_wdata_in & `PDG_SRW0_IMPL
                        & device_capabilities_1_in;
  assign srw0_refused = reg_wdata_in & `PDG_SRW0_IMPL
                        & ~device_capabilities_1_in;

  always @* begin
    srw0_d = srw0_q;
    if (wr_srw0) begin
      srw0_d = srw0_wr_val;
    end
  end

  always @* begin
    dsg_d = dsg_q;
    if (wr_dsg) begin
      // only bits 4:0 exist; upper write data is dropped
      dsg_d = reg_wdata_in[NUM_PORTS-1:0];
    end
  end

  // soft reset word; every unit comes out of a system reset released
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      srw0_q <= `PDG_SRW0_RST;
    end else begin
      srw0_q <= srw0_d;
    end
  end

  // deep-sleep gating word; every port starts unclocked
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      dsg_q <= {NUM_PORTS{1'b0}};
    end else begin
      dsg_q <= dsg_d;
    end
  end

  // the mask only gates the interrupt line; status records regardless
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      irq_mask_q <= {`PDG_NUM_EVENTS{1'b0}};
    end else if (wr_mask) begin
      irq_mask_q <= reg_wdata_in[`PDG_NUM_EVENTS-1:0];
    end
  end

  // gating word in force for the present power mode
  // without auto gating the run word holds in every mode, so the sleep
  // and deep-sleep words are never applied
  reg [NUM_PORTS-1:0] gate_sel;

  always @* begin
    gate_sel = run_port_clock_gate_in;
    if (auto_clock_gating_enable_in) begin
      case (power_mode_in)
        `PDG_MODE_RUN: begin
          gate_sel = run_port_clock_gate_in;
        end
        `PDG_MODE_SLEEP: begin
          gate_sel = sleep_port_clock_gate_in;
        end
        `PDG_MODE_DEEP: begin
          gate_sel = dsg_q;
        end
        default: begin
          gate_sel = run_port_clock_gate_in;
        end
      endcase
    end
  end

  // enables are registered so the gates downstream see glitch-free levels
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      port_clock_enable_out <= {NUM_PORTS{1'b0}};
    end else begin
      port_clock_enable_out <= gate_sel;
    end
  end

  // access check against the enables actually driven this cycle
  wire                 sel_clocked;
  wire [NUM_PORTS-1:0] sel_onehot;
  wire [NUM_PORTS-1:0] sel_hit;

  // one select decoder per port; codes past the last port match none,
  // so they fault as well and never index past the enable vector
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_port
      assign sel_onehot[gi] = (port_access_sel_in == gi);
      assign sel_hit[gi]    = sel_onehot[gi] & port_clock_enable_out[gi];
    end
  endgenerate

  assign sel_clocked = |sel_hit;

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      bus_fault_out      <= 1'b0;
      port_access_ok_out <= 1'b0;
    end else begin
      bus_fault_out      <= port_access_in & ~sel_clocked;
      port_access_ok_out <= port_access_in & sel_clocked;
    end
  end

  // peripheral resets follow the stored word one clock late; the flops
  // keep decode glitches of a register write off the reset lines
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pwm_reset_out <= 1'b0;
    end else begin
      pwm_reset_out <= srw0_q[`PDG_SRW0_PWM_BIT];
    end
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      adc0_reset_out <= 1'b0;
    end else begin
      adc0_reset_out <= srw0_q[`PDG_SRW0_ADC0_BIT];
    end
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      watchdog_reset_ctl_out <= 1'b0;
    end else begin
      watchdog_reset_ctl_out <= srw0_q[`PDG_SRW0_WDOG_BIT];
    end
  end

  // events for the interrupt flags
  // previous enables, so a change of the word in force is seen
  reg  [NUM_PORTS-1:0]       gate_prev_q;
  wire [`PDG_NUM_EVENTS-1:0] events;
  wire [`PDG_NUM_EVENTS-1:0] irq_flags;

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      gate_prev_q <= {NUM_PORTS{1'b0}};
    end else begin
      gate_prev_q <= port_clock_enable_out;
    end
  end

  // each source lasts one cycle; the flags hold it until cleared
  wire ev_fault;
  wire ev_refused;
  wire ev_gate;

  assign ev_fault   = bus_fault_out;
  // an asked-for unit that the capabilities lack is dropped silently,
  // so software is told here instead
  assign ev_refused = wr_srw0 & (|srw0_refused);
  assign ev_gate    = |(gate_prev_q ^ port_clock_enable_out);

  assign events[`PDG_EV_BUS_FAULT]   = ev_fault;
  assign events[`PDG_EV_RST_MASKED]  = ev_refused;
  assign events[`PDG_EV_GATE_CHANGE] = ev_gate;

  // set-wins-over-clear lives in the flag module, in one place
  pdg_event_flags #(
    .WIDTH (`PDG_NUM_EVENTS)
  ) u_flags (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .set_in      (events),
    .clear_en_in (wr_stat),
    .clear_in    (reg_wdata_in[`PDG_NUM_EVENTS-1:0]),
    .mask_in     (irq_mask_q),
    .flags_out   (irq_flags),
    .irq_out     (irq_out)
  );

  // each register as a full word; reserved bits are tied to zero here
  // so no later path can leak stale data into them
  wire [DATA_W-1:0] srw0_word;
  wire [DATA_W-1:0] dsg_word;
  wire [DATA_W-1:0] stat_word;
  wire [DATA_W-1:0] mask_word;
  wire [DATA_W-1:0] eff_word;

  assign srw0_word = srw0_q & `PDG_SRW0_IMPL;
  assign dsg_word  = {{(DATA_W-NUM_PORTS){1'b0}}, dsg_q};
  assign stat_word = {{(DATA_W-`PDG_NUM_EVENTS){1'b0}}, irq_flags};
  assign mask_word = {{(DATA_W-`PDG_NUM_EVENTS){1'b0}}, irq_mask_q};
  assign eff_word  = {{(DATA_W-NUM_PORTS){1'b0}}, port_clock_enable_out};

  // read mux; unmapped locations read zero
  reg [DATA_W-1:0] rd_val;

  always @* begin
    rd_val = `PDG_ZERO_WORD;
    if (sel_srw0) begin
      rd_val = srw0_word;
    end else if (sel_dsg) begin
      rd_val = dsg_word;
    end else if (sel_stat) begin
      rd_val = stat_word;
    end else if (sel_mask) begin
      rd_val = mask_word;
    end else if (sel_eff) begin
      rd_val = eff_word;
    end
  end

  // data stand only in the cycle after the strobe
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= `PDG_ZERO_WORD;
    end else if (rd_take) begin
      reg_rdata_out <= rd_val;
    end else begin
      reg_rdata_out <= `PDG_ZERO_WORD;
    end
  end

endmodule // pdg_gate_reset

`default_nettype wire

//--- pdg_gate_reset_chk.sv
// assertions on the port gating and soft reset block ports
`timescale 1ns/10ps
`default_nettype none
`include "pdg_consts.vh"
module pdg_gate_reset_chk (
  // clock, reset and register port
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  // gating state and port access
  input wire logic [1:0]  power_mode_in,
  input wire logic        auto_clock_gating_enable_in,
  input wire logic [4:0]  run_port_clock_gate_in,
  input wire logic [4:0]  sleep_port_clock_gate_in,
  input wire logic [31:0] device_capabilities_1_in,
  input wire logic        port_access_in,
  input wire logic [2:0]  port_access_sel_in,
  // block outputs
  input wire logic        bus_fault_out,
  input wire logic        port_access_ok_out,
  input wire logic [4:0]  port_clock_enable_out,
  input wire logic        pwm_reset_out,
  input wire logic        adc0_reset_out,
  input wire logic        watchdog_reset_ctl_out,
  input wire logic        irq_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  logic [2:0] rst_bits_q;
  wire        srw_wr = reg_write_in && reg_addr_in == `PDG_SRW0_OFS;
  wire [31:0] masked = reg_wdata_in & device_capabilities_1_in;
  // selects above port e never have a clock
  wire        gated = port_access_sel_in > 3'h4 ||
                      !port_clock_enable_out[port_access_sel_in];
  always_ff @(posedge clock_in)
    rst_bits_q <= {masked[20], masked[16], masked[3]};

  a_rdata_idle_zero:
    assert property (!reg_read_in |=> reg_rdata_out == 32'h0)
    else $error("read data not zero outside a read");
  a_srw_rsvd_zero:
    assert property (reg_read_in && reg_addr_in == `PDG_SRW0_OFS
      |=> (reg_rdata_out & ~`PDG_SRW0_IMPL) == 32'h0)
    else $error("reserved reset word bits not zero");
  a_dsg_rsvd_zero:
    assert property (reg_read_in && reg_addr_in == `PDG_DSG_OFS
      |=> (reg_rdata_out & ~`PDG_DSG_IMPL) == 32'h0)
    else $error("reserved gating word bits not zero");
  a_run_gate_sel:
    assert property (!auto_clock_gating_enable_in
      |=> port_clock_enable_out == $past(run_port_clock_gate_in))
    else $error("port enables not the run word");
  a_sleep_gate_sel:
    assert property (auto_clock_gating_enable_in &&
      power_mode_in == `PDG_MODE_SLEEP
      |=> port_clock_enable_out == $past(sleep_port_clock_gate_in))
    else $error("port enables not the sleep word");
  a_fault_on_gated:
    assert property (port_access_in && gated
      |=> bus_fault_out && !port_access_ok_out)
    else $error("no bus fault on gated port");
  a_ok_on_clocked:
    assert property (port_access_in && !gated
      |=> port_access_ok_out && !bus_fault_out)
    else $error("clocked port access not completed");
  a_answer_only_pulse:
    assert property (!port_access_in
      |=> !bus_fault_out && !port_access_ok_out)
    else $error("access answer without access");
  a_reset_out_lag:
    assert property (srw_wr ##1 !srw_wr |=> {pwm_reset_out,
      adc0_reset_out, watchdog_reset_ctl_out} == $past(rst_bits_q))
    else $error("reset outputs differ from masked write");

  c_fault: cover property (bus_fault_out);
  c_ok: cover property (port_access_ok_out);
  c_irq: cover property ($rose(irq_out));
endmodule // pdg_gate_reset_chk
`default_nettype wire

//--- testbench.sv
// self-checking bench for the port gating and soft reset block
`timescale 1ns/10ps
`default_nettype none
`include "pdg_consts.vh"
module testbench;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [11:0] reg_addr_in = 12'h000;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic        reg_write_in = 1'b0;
  logic        reg_read_in = 1'b0;
  logic [1:0]  power_mode_in = 2'h0;
  logic        auto_clock_gating_enable_in = 1'b0;
  logic [4:0]  run_port_clock_gate_in = 5'h01;
  logic [4:0]  sleep_port_clock_gate_in = 5'h02;
  logic [31:0] device_capabilities_1_in = 32'hffff_ffff;
  logic        port_access_in = 1'b0;
  logic [2:0]  port_access_sel_in = 3'h0;
  wire  [31:0] reg_rdata_out;
  wire  [4:0]  port_clock_enable_out;
  wire         bus_fault_out, port_access_ok_out, irq_out;
  wire         pwm_reset_out, adc0_reset_out, watchdog_reset_ctl_out;
  wire  [2:0]  rsts = {pwm_reset_out, adc0_reset_out,
                       watchdog_reset_ctl_out};
  int          err_count = 0;
  int          n_compared = 0;
  int          bits [3] = '{20, 16, 3};
  // auto bit, mode, expected port enables
  logic [7:0]  gm [5] = '{8'h41, 8'h81, 8'ha2, 8'hc4, 8'he1};

  always #50 clock_in = ~clock_in;
  pdg_gate_reset dut (.*);

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_write_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, m);
    @(posedge clock_in);
    reg_read_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    #1 chk("rdata", e, reg_rdata_out & m);
  endtask
  task automatic acc(input logic [2:0] s, input logic f);
    @(posedge clock_in);
    port_access_in <= 1'b1;
    port_access_sel_in <= s;
    @(posedge clock_in);
    port_access_in <= 1'b0;
    #1 chk("fault", 32'(f), 32'(bus_fault_out));
    chk("ok", 32'(!f), 32'(port_access_ok_out));
  endtask
  task automatic final_report;
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #2000000;
    err_count++;
    final_report();
  end

  initial begin
    @(posedge clock_in);
    #1 chk("reset", 32'h0, 32'({port_clock_enable_out, rsts}));
    @(posedge clock_in) rst_in <= 1'b0;
    rd(`PDG_DSG_OFS, 32'h0, '1);
    rd(`PDG_SRW0_OFS, 32'h0, '1);
    wr(`PDG_DSG_OFS, 32'hffff_ffff);
    rd(`PDG_DSG_OFS, 32'h0000_001f, '1);
    wr(`PDG_SRW0_OFS, 32'hffff_ffff);
    rd(`PDG_SRW0_OFS, 32'h0011_0008, '1);
    chk("rsts", 32'h7, 32'(rsts));
    foreach (bits[i]) begin
      @(posedge clock_in) device_capabilities_1_in <= 32'h1 << bits[i];
      wr(`PDG_SRW0_OFS, 32'h0011_0008);
      rd(`PDG_SRW0_OFS, 32'h1 << bits[i], '1);
      chk("rsts", 32'h4 >> i, 32'(rsts));
    end
    @(posedge clock_in) device_capabilities_1_in <= 32'hffff_ffff;
    wr(`PDG_SRW0_OFS, 32'h0);
    rd(`PDG_SRW0_OFS, 32'h0, '1);
    chk("rsts", 32'h0, 32'(rsts));
    wr(12'h100, 32'hffff_ffff);
    rd(12'h100, 32'h0, '1);
    // interrupt: raise masked, unmask, then clear
    wr(`PDG_IRQ_MASK_OFS, 32'h0);
    rd(`PDG_IRQ_STAT_OFS, 32'h6, '1);
    wr(`PDG_IRQ_STAT_OFS, 32'h7);
    rd(`PDG_IRQ_STAT_OFS, 32'h0, '1);
    acc(3'h1, 1'b1);
    acc(3'h0, 1'b0);
    rd(`PDG_IRQ_STAT_OFS, 32'h1, 32'h1);
    chk("irq", 32'h0, 32'(irq_out));
    wr(`PDG_IRQ_MASK_OFS, 32'h1);
    cyc(1);
    chk("irq", 32'h1, 32'(irq_out));
    wr(`PDG_IRQ_STAT_OFS, 32'h1);
    cyc(1);
    chk("irq", 32'h0, 32'(irq_out));
    wr(`PDG_DSG_OFS, 32'h4);
    foreach (gm[i]) begin
      @(posedge clock_in)
        {auto_clock_gating_enable_in, power_mode_in} <= gm[i][7:5];
      cyc(2);
      chk("en", 32'(gm[i][4:0]), 32'(port_clock_enable_out));
      rd(`PDG_EFF_GATE_OFS, 32'(gm[i][4:0]), '1);
    end
    @(posedge clock_in) power_mode_in <= `PDG_MODE_DEEP;
    for (int p = 0; p < 5; p++) begin
      wr(`PDG_DSG_OFS, 32'h1 << p);
      cyc(1);
      acc(3'(p), 1'b0);
      acc(3'((p + 1) % 5), 1'b1);
    end
    acc(3'h5, 1'b1);
    final_report();
  end
endmodule // testbench

bind pdg_gate_reset pdg_gate_reset_chk u_chk (.*);
`default_nettype wire
